/* design/hub_cfg_pkg.sv */
package hub_cfg_pkg;

	localparam int NUM_PORTS     = 2;
	localparam int TT_PER_PORT   = 1;
	localparam int TT_NP_BUFFERS = 4;

	localparam int CLK_HZ          = 40_000_000;
	localparam int OC_STEP_US      = 2000;
	localparam int OC_STEP_CYCLES  = (CLK_HZ / 1_000_000) * OC_STEP_US;
	localparam int RECONNECT_US    = 10;
	localparam int RECONNECT_CYCLES = (CLK_HZ / 1_000_000) * RECONNECT_US;
	localparam int RECONNECT_W     = 9;
	localparam logic [RECONNECT_W-1:0] RECONNECT_LAST = RECONNECT_W'(RECONNECT_CYCLES - 1);

	localparam logic [6:0] SERIAL_SLAVE_ADDR = 7'h2c;

	// Descriptor byte indices
	localparam logic [3:0] DESC_VID_LSB   = 4'h0;
	localparam logic [3:0] DESC_VID_MSB   = 4'h1;
	localparam logic [3:0] DESC_PID_LSB   = 4'h2;
	localparam logic [3:0] DESC_PID_MSB   = 4'h3;
	localparam logic [3:0] DESC_REL_LSB   = 4'h4;
	localparam logic [3:0] DESC_REL_MSB   = 4'h5;
	localparam logic [3:0] DESC_CFG1      = 4'h6;
	localparam logic [3:0] DESC_CFG2      = 4'h7;
	localparam logic [3:0] DESC_FIXED     = 4'h8;
	localparam logic [3:0] DESC_DIS_SELF  = 4'h9;
	localparam logic [3:0] DESC_DIS_BUS   = 4'ha;
	localparam logic [3:0] DESC_MAXP_SELF = 4'hb;
	localparam logic [3:0] DESC_MAXP_BUS  = 4'hc;
	localparam logic [3:0] DESC_HUBC_SELF = 4'hd;
	localparam logic [3:0] DESC_HUBC_BUS  = 4'he;
	localparam logic [3:0] DESC_PON       = 4'hf;
	localparam int         DESC_BYTES     = 16;

	// Field positions inside the option bytes
	localparam int CFG1_SELF_BIT    = 7;
	localparam int CFG1_HS_DIS_BIT  = 5;
	localparam int CFG1_EOP_DIS_BIT = 4;
	localparam int CFG1_COMPOUND_BIT = 3;
	localparam int CFG1_CS_BIT      = 1;
	localparam int CFG2_DYN_BIT     = 7;
	localparam int CFG2_OC_LSB      = 4;
	localparam int OC_W             = 2;

	// Internal defaults; identifier values are arbitrary
	localparam logic [15:0] DEF_VID       = 16'h1234;
	localparam logic [15:0] DEF_PID       = 16'h0002;
	localparam logic [15:0] DEF_REL       = 16'h0100;
	localparam logic [7:0]  DEF_CFG2      = 8'h90;
	localparam logic [7:0]  DEF_MAXP_SELF = 8'h01;
	localparam logic [7:0]  DEF_MAXP_BUS  = 8'h64;
	localparam logic [7:0]  DEF_PON       = 8'h32;

	// Avalon byte addresses
	localparam int          ADDR_W          = 8;
	localparam logic [7:0]  REG_DESC_LAST   = 8'h3c;
	localparam logic [7:0]  REG_CTRL        = 8'h40;
	localparam logic [7:0]  REG_STATUS      = 8'h44;
	localparam int          CTRL_COMMIT_BIT = 0;

	typedef enum logic [1:0]
	{
		SRC_RESERVED = 2'h0,
		SRC_SERIAL   = 2'h1,
		SRC_INTERNAL = 2'h2,
		SRC_EEPROM   = 2'h3
	} cfg_src_type;

	typedef enum logic [2:0]
	{
		ST_STRAP      = 3'b000,
		ST_LOAD       = 3'b001,
		ST_APPLY      = 3'b010,
		ST_ATTACHED   = 3'b011,
		ST_DISCONNECT = 3'b100,
		ST_HALT       = 3'b101
	} state_type;

	typedef struct packed
	{
		logic [15:0]          vendor_id;
		logic [15:0]          product_id;
		logic [15:0]          release_bcd;
		logic                 hs_disable;
		logic                 eop_disable;
		logic                 cs_ganged;
		logic                 compound;
		logic                 dynamic_power;
		logic                 self_cfg;
		logic [NUM_PORTS-1:0] fixed_ports;
		logic [NUM_PORTS-1:0] dis_self;
		logic [NUM_PORTS-1:0] dis_bus;
		logic [OC_W-1:0]      oc_steps;
		logic [7:0]           maxp_self;
		logic [7:0]           maxp_bus;
		logic [7:0]           hubc_self;
		logic [7:0]           hubc_bus;
		logic [7:0]           pon_time;
	} hub_settings_type;

endpackage

/* design/hub_cfg_avmm.sv */
`timescale 1ns/1ps
`default_nettype none
module hub_cfg_avmm
(
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_b,
	input  wire logic        i_read,
	input  wire logic        i_write,
	input  wire logic [31:0] i_rd_value,
	output logic      [31:0] o_readdata,
	output logic             o_waitrequest,
	output logic             o_wr_fire
);
	import hub_cfg_pkg::*;

	logic ack;
	wire  req = i_read | i_write;

	// One wait cycle gives the read mux a full cycle before data is held
	assign o_waitrequest = req & ~ack;
	assign o_wr_fire     = i_write & ack;

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			ack <= 1'b0;
		else
			ack <= req & ~ack;
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			o_readdata <= 32'h0000_0000;
		else if (i_read && !ack)
			o_readdata <= i_rd_value;
	end

endmodule
`default_nettype wire

/* design/hub_oc_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module hub_oc_timer
(
	input  wire logic                         i_sys_clk,
	input  wire logic                         i_rst_b,
	input  wire logic                         i_sense_on,
	input  wire logic                         i_over_current,
	input  wire logic                         i_step,
	input  wire logic [hub_cfg_pkg::OC_W-1:0] i_delay_steps,
	output logic                              o_oc_report
);
	import hub_cfg_pkg::*;

	logic [OC_W:0] steps;
	// A zero delay still waits one step so a glitch is never reported
	wire  [OC_W:0] limit   = (i_delay_steps == '0) ? (OC_W+1)'(1) : {1'b0, i_delay_steps};
	wire           reached = (steps >= limit);
	wire           active  = i_sense_on & i_over_current;

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			steps <= '0;
		else if (!active)
			steps <= '0;
		else if (i_step && !reached)
			steps <= steps + (OC_W+1)'(1);
	end

	assign o_oc_report = active & reached;

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);

	property p_oc_needs_persist;
		o_oc_report |-> $past(active) && steps != '0;
	endproperty
	a_oc_needs_persist: assert property (p_oc_needs_persist) else $error("over-current reported too early");

	property p_oc_drop;
		!active |-> !o_oc_report;
	endproperty
	a_oc_drop: assert property (p_oc_drop) else $error("over-current reported without condition");

endmodule
`default_nettype wire

/* design/hub_cfg_loader.sv */
// How it works
// - Config source taken from the two select straps just after reset release.
// - 01 serial slave at 0101100, 10 internal defaults, 11 EEPROM, 00 reserved.
// - 16-bit vendor id loaded externally, built-in value under internal defaults.
// - 16-bit product id loaded externally, built-in value under internal defaults.
// - 16-bit BCD release number loaded externally or built-in default.
// - Internal defaults: local power sense picks self or bus powered.
// - High-speed disable forces full-speed only enumeration.
// - End-of-packet setting acts only in full-speed operation.
// - Current sensing ganged or none; internal defaults follow power mode.
// - Strap configuration: any fixed port makes the hub report compound.
// - Internal defaults: fixed port straps mark ports non-removable to the host.
// - Self-powered: self disable mask keeps ports permanently off.
// - Bus-powered: bus disable mask keeps ports permanently off.
// - Dynamic switching: self-powered exactly while local power is present; the old mode is held through the disconnect until reattach.
// - Power source change drops downstream power, ports and upstream attach.
// - Reattach as bus powered without local power, self powered with it.
// - Over-current must persist the configured 2ms steps before report.
// - Self-powered mode reports the self max-power value in 2mA units.
// - Bus-powered mode reports the bus max-power value in 2mA units.
// - One transaction translator per port, four non-periodic buffers each.
//
// Our own choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module hub_cfg_loader
#(
	parameter int OC_STEP_CYCLES = hub_cfg_pkg::OC_STEP_CYCLES
)
(
	input  wire logic                                i_sys_clk,
	input  wire logic                                i_rst_b,
	input  wire logic                                i_config_select_high,
	input  wire logic                                i_config_select_low,
	input  wire logic                                i_local_power_sense,
	input  wire logic [hub_cfg_pkg::NUM_PORTS-1:0]   i_fixed_port_straps,
	input  wire logic                                i_over_current,
	input  wire logic                                i_link_full_speed,
	input  wire logic [hub_cfg_pkg::ADDR_W-1:0]      i_avs_address,
	input  wire logic                                i_avs_read,
	input  wire logic                                i_avs_write,
	input  wire logic [31:0]                         i_avs_writedata,
	output logic      [31:0]                         o_avs_readdata,
	output logic                                     o_avs_waitrequest,
	output hub_cfg_pkg::hub_settings_type            o_settings,
	output hub_cfg_pkg::cfg_src_type                 o_cfg_source,
	output logic                                     o_serial_slave_en,
	output logic      [6:0]                          o_serial_slave_addr,
	output logic                                     o_eeprom_load_en,
	output logic                                     o_self_powered,
	output logic                                     o_hs_enable,
	output logic                                     o_fs_eop_enable,
	output logic      [7:0]                          o_max_power,
	output logic      [7:0]                          o_hub_current,
	output logic                                     o_upstream_attach,
	output logic      [hub_cfg_pkg::NUM_PORTS-1:0]   o_port_power,
	output logic      [hub_cfg_pkg::NUM_PORTS-1:0]   o_port_enable,
	output logic      [hub_cfg_pkg::NUM_PORTS-1:0]   o_tt_enable,
	output logic                                     o_oc_report
);
	import hub_cfg_pkg::*;

	localparam int STEP_W = $clog2(OC_STEP_CYCLES);

	state_type            state;
	state_type            next_state;
	cfg_src_type          src;
	hub_settings_type     settings;
	logic                 self_powered;
	logic                 attach;
	logic [RECONNECT_W-1:0] recon_cnt;
	logic [STEP_W-1:0]    step_cnt;
	logic [7:0]           desc [DESC_BYTES];
	logic                 wr_fire;
	logic [31:0]          rd_value;

	// Bus decode
	wire       addr_desc   = (i_avs_address <= REG_DESC_LAST) && (i_avs_address[1:0] == 2'h0);
	wire       addr_ctrl   = (i_avs_address == REG_CTRL);
	wire       addr_status = (i_avs_address == REG_STATUS);
	wire [3:0] desc_idx    = i_avs_address[5:2];
	// Descriptor writes only land while an external source is loading
	wire       desc_wr     = wr_fire && addr_desc && (state == ST_LOAD);
	wire       commit      = wr_fire && addr_ctrl && i_avs_writedata[CTRL_COMMIT_BIT] && (state == ST_LOAD);
	wire       power_change = (state == ST_ATTACHED) && settings.dynamic_power
	                          && (i_local_power_sense != self_powered);
	wire       recon_done  = (recon_cnt == RECONNECT_LAST);
	wire       step_pulse  = (step_cnt == STEP_W'(OC_STEP_CYCLES - 1));

	assign rd_value = addr_desc   ? {24'h00_0000, desc[desc_idx]} :
	                  addr_status ? {24'h00_0000, 1'b0, state, src, self_powered, attach} :
	                                32'h0000_0000;

	hub_cfg_avmm u_avmm
	(
		.i_sys_clk     (i_sys_clk),
		.i_rst_b       (i_rst_b),
		.i_read        (i_avs_read),
		.i_write       (i_avs_write),
		.i_rd_value    (rd_value),
		.o_readdata    (o_avs_readdata),
		.o_waitrequest (o_avs_waitrequest),
		.o_wr_fire     (wr_fire)
	);

	// Descriptor image, one byte per entry
	genvar g;
	generate
		for (g = 0; g < DESC_BYTES; g++)
		begin : g_desc
			always_ff @(posedge i_sys_clk or negedge i_rst_b)
			begin
				if (!i_rst_b)
					desc[g] <= 8'h00;
				else if (desc_wr && desc_idx == 4'(g))
					desc[g] <= i_avs_writedata[7:0];
			end
		end
	endgenerate

	// Settings taken from the downloaded image
	hub_settings_type loaded_settings;
	assign loaded_settings.vendor_id     = {desc[DESC_VID_MSB], desc[DESC_VID_LSB]};
	assign loaded_settings.product_id    = {desc[DESC_PID_MSB], desc[DESC_PID_LSB]};
	assign loaded_settings.release_bcd   = {desc[DESC_REL_MSB], desc[DESC_REL_LSB]};
	assign loaded_settings.hs_disable    = desc[DESC_CFG1][CFG1_HS_DIS_BIT];
	assign loaded_settings.eop_disable   = desc[DESC_CFG1][CFG1_EOP_DIS_BIT];
	assign loaded_settings.cs_ganged     = desc[DESC_CFG1][CFG1_CS_BIT];
	assign loaded_settings.compound      = desc[DESC_CFG1][CFG1_COMPOUND_BIT];
	assign loaded_settings.self_cfg      = desc[DESC_CFG1][CFG1_SELF_BIT];
	assign loaded_settings.dynamic_power = desc[DESC_CFG2][CFG2_DYN_BIT];
	assign loaded_settings.oc_steps      = desc[DESC_CFG2][CFG2_OC_LSB +: OC_W];
	assign loaded_settings.fixed_ports   = desc[DESC_FIXED][NUM_PORTS:1];
	assign loaded_settings.dis_self      = desc[DESC_DIS_SELF][NUM_PORTS:1];
	assign loaded_settings.dis_bus       = desc[DESC_DIS_BUS][NUM_PORTS:1];
	assign loaded_settings.maxp_self     = desc[DESC_MAXP_SELF];
	assign loaded_settings.maxp_bus      = desc[DESC_MAXP_BUS];
	assign loaded_settings.hubc_self     = desc[DESC_HUBC_SELF];
	assign loaded_settings.hubc_bus      = desc[DESC_HUBC_BUS];
	assign loaded_settings.pon_time      = desc[DESC_PON];

	// Built-in settings with strap inputs
	hub_settings_type default_settings;
	assign default_settings.vendor_id     = DEF_VID;
	assign default_settings.product_id    = DEF_PID;
	assign default_settings.release_bcd   = DEF_REL;
	assign default_settings.hs_disable    = 1'b0;
	assign default_settings.eop_disable   = 1'b0;
	assign default_settings.cs_ganged     = i_local_power_sense;
	assign default_settings.compound      = |i_fixed_port_straps;
	assign default_settings.self_cfg      = i_local_power_sense;
	assign default_settings.dynamic_power = DEF_CFG2[CFG2_DYN_BIT];
	assign default_settings.oc_steps      = DEF_CFG2[CFG2_OC_LSB +: OC_W];
	assign default_settings.fixed_ports   = i_fixed_port_straps;
	assign default_settings.dis_self      = '0;
	assign default_settings.dis_bus       = '0;
	assign default_settings.maxp_self     = DEF_MAXP_SELF;
	assign default_settings.maxp_bus      = DEF_MAXP_BUS;
	assign default_settings.hubc_self     = DEF_MAXP_SELF;
	assign default_settings.hubc_bus      = DEF_MAXP_BUS;
	assign default_settings.pon_time      = DEF_PON;

	wire hub_settings_type apply_settings = (src == SRC_INTERNAL) ? default_settings : loaded_settings;
	// With dynamic switching the sense pin wins over the configured mode
	wire apply_self = apply_settings.dynamic_power ? i_local_power_sense : apply_settings.self_cfg;

	always_comb
	begin
		next_state = state;
		case (state)
			ST_STRAP:
			begin
				if ({i_config_select_high, i_config_select_low} == SRC_RESERVED)
					next_state = ST_HALT;
				else if ({i_config_select_high, i_config_select_low} == SRC_INTERNAL)
					next_state = ST_APPLY;
				else
					next_state = ST_LOAD;
			end
			ST_LOAD:
			begin
				if (commit)
					next_state = ST_APPLY;
			end
			ST_APPLY:      next_state = ST_ATTACHED;
			ST_ATTACHED:
			begin
				if (power_change)
					next_state = ST_DISCONNECT;
			end
			ST_DISCONNECT:
			begin
				if (recon_done)
					next_state = ST_ATTACHED;
			end
			ST_HALT:       next_state = ST_HALT;
			default:       next_state = ST_HALT;
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			state <= ST_STRAP;
		else
			state <= next_state;
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			src <= SRC_RESERVED;
		else if (state == ST_STRAP)
			src <= cfg_src_type'({i_config_select_high, i_config_select_low});
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			settings <= '0;
		else if (state == ST_APPLY)
			settings <= apply_settings;
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			self_powered <= 1'b0;
		else if (state == ST_APPLY)
			self_powered <= apply_self;
		else if (state == ST_DISCONNECT && recon_done)
			self_powered <= i_local_power_sense;
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			attach <= 1'b0;
		else
			attach <= (next_state == ST_ATTACHED) && !power_change;
	end

	// Hold time while detached so the host sees a clean disconnect
	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			recon_cnt <= '0;
		else if (state != ST_DISCONNECT)
			recon_cnt <= '0;
		else if (!recon_done)
			recon_cnt <= recon_cnt + RECONNECT_W'(1);
	end

	// 2ms step enable, restarted at over-current onset so every counted step is a full one
	always_ff @(posedge i_sys_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			step_cnt <= '0;
		else if (step_pulse || !(settings.cs_ganged && attach && i_over_current))
			step_cnt <= '0;
		else
			step_cnt <= step_cnt + STEP_W'(1);
	end

	hub_oc_timer u_oc
	(
		.i_sys_clk      (i_sys_clk),
		.i_rst_b        (i_rst_b),
		.i_sense_on     (settings.cs_ganged & attach),
		.i_over_current (i_over_current),
		.i_step         (step_pulse),
		.i_delay_steps  (settings.oc_steps),
		.o_oc_report    (o_oc_report)
	);

	wire [NUM_PORTS-1:0] port_disabled = self_powered ? settings.dis_self : settings.dis_bus;
	wire                 fs_operation  = settings.hs_disable | i_link_full_speed;

	// Each port owns its own translator; four non-periodic buffers per translator
	generate
		for (g = 0; g < NUM_PORTS; g++)
		begin : g_port
			assign o_port_enable[g] = attach & ~port_disabled[g];
			assign o_port_power[g]  = attach & ~port_disabled[g];
			assign o_tt_enable[g]   = o_port_enable[g] & ~fs_operation;
		end
	endgenerate

	assign o_settings          = settings;
	assign o_cfg_source        = src;
	assign o_serial_slave_en   = (src == SRC_SERIAL) && (state == ST_LOAD);
	assign o_serial_slave_addr = SERIAL_SLAVE_ADDR;
	assign o_eeprom_load_en    = (src == SRC_EEPROM) && (state == ST_LOAD);
	assign o_self_powered      = self_powered;
	assign o_hs_enable         = ~settings.hs_disable & attach;
	assign o_fs_eop_enable     = fs_operation & ~settings.eop_disable & attach;
	assign o_max_power         = self_powered ? settings.maxp_self : settings.maxp_bus;
	assign o_hub_current       = self_powered ? settings.hubc_self : settings.hubc_bus;
	assign o_upstream_attach   = attach;

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);

	sequence s_power_change;
		state == ST_ATTACHED && settings.dynamic_power && (i_local_power_sense != self_powered);
	endsequence

	sequence s_reattach;
		state == ST_DISCONNECT && recon_done;
	endsequence

	property p_strap_capture;
		state == ST_STRAP |=> src == $past({i_config_select_high, i_config_select_low});
	endproperty
	a_strap_capture: assert property (p_strap_capture) else $error("straps not captured");

	property p_reserved_halt;
		state == ST_STRAP && {i_config_select_high, i_config_select_low} == SRC_RESERVED |=> ##1 !attach [*4];
	endproperty
	a_reserved_halt: assert property (p_reserved_halt) else $error("reserved code attached");

	property p_default_ids;
		state == ST_APPLY && src == SRC_INTERNAL |=> settings.vendor_id == DEF_VID && settings.product_id == DEF_PID;
	endproperty
	a_default_ids: assert property (p_default_ids) else $error("built-in ids not used");

	property p_loaded_pid;
		state == ST_APPLY && src != SRC_INTERNAL |=> settings.product_id == $past({desc[DESC_PID_MSB], desc[DESC_PID_LSB]});
	endproperty
	a_loaded_pid: assert property (p_loaded_pid) else $error("product id not loaded");

	property p_loaded_rel;
		state == ST_APPLY && src != SRC_INTERNAL |=> settings.release_bcd == $past({desc[DESC_REL_MSB], desc[DESC_REL_LSB]});
	endproperty
	a_loaded_rel: assert property (p_loaded_rel) else $error("release number not loaded");

	property p_hs_off;
		settings.hs_disable |-> !o_hs_enable && o_tt_enable == '0;
	endproperty
	a_hs_off: assert property (p_hs_off) else $error("high speed offered while disabled");

	property p_eop_fs_only;
		o_fs_eop_enable |-> fs_operation;
	endproperty
	a_eop_fs_only: assert property (p_eop_fs_only) else $error("eop outside full speed");

	property p_compound;
		state == ST_APPLY && src == SRC_INTERNAL && |i_fixed_port_straps |=> settings.compound;
	endproperty
	a_compound: assert property (p_compound) else $error("compound not reported");

	property p_port_disable;
		(o_port_enable & (self_powered ? settings.dis_self : settings.dis_bus)) == '0;
	endproperty
	a_port_disable: assert property (p_port_disable) else $error("disabled port enabled");

	property p_power_drop;
		s_power_change |=> !o_upstream_attach && o_port_power == '0;
	endproperty
	a_power_drop: assert property (p_power_drop) else $error("no disconnect on power change");

	property p_reattach_mode;
		s_reattach |=> self_powered == $past(i_local_power_sense) ##1 o_upstream_attach;
	endproperty
	a_reattach_mode: assert property (p_reattach_mode) else $error("wrong mode after reattach");

	property p_max_power;
		o_max_power == (self_powered ? settings.maxp_self : settings.maxp_bus);
	endproperty
	a_max_power: assert property (p_max_power) else $error("wrong max power");

	property p_frozen;
		(state == ST_ATTACHED || state == ST_DISCONNECT) |=> $stable(settings);
	endproperty
	a_frozen: assert property (p_frozen) else $error("settings changed after load");

endmodule
`default_nettype wire

/* tb/hub_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module hub_host_model
(
	input  wire logic i_hs_enable,
	input  wire logic i_attach,
	output logic      o_full_speed
);
	// Host falls back to full speed when no high speed is offered
	assign o_full_speed = i_attach & ~i_hs_enable;
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import hub_cfg_pkg::*;
	logic clk, rst_b, shi, slo, sense, oc, rd, wr, fs, wreq, att, selfp, hs, ocr, sen, een, eop;
	logic [1:0] fixed, pen, src, ppow, tten;
	logic [7:0] addr, maxp, hcur;
	logic [6:0] saddr;
	logic [31:0] wdata, rdat, rdata;
	hub_settings_type st;
	int bad_count, num_checks;
	hub_cfg_loader #(.OC_STEP_CYCLES(8)) hub_cfg_loader_inst
	(
		.i_sys_clk(clk), .i_rst_b(rst_b), .i_config_select_high(shi), .i_config_select_low(slo),
		.i_local_power_sense(sense), .i_fixed_port_straps(fixed), .i_over_current(oc),
		.i_link_full_speed(fs), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
		.i_avs_writedata(wdata), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .o_settings(st),
		.o_cfg_source(src), .o_serial_slave_en(sen), .o_serial_slave_addr(saddr), .o_eeprom_load_en(een),
		.o_self_powered(selfp), .o_hs_enable(hs), .o_fs_eop_enable(eop), .o_max_power(maxp),
		.o_hub_current(hcur), .o_upstream_attach(att), .o_port_power(ppow), .o_port_enable(pen),
		.o_tt_enable(tten), .o_oc_report(ocr)
	);
	hub_host_model hub_host_model_inst (.i_hs_enable(hs), .i_attach(att), .o_full_speed(fs));
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic results;
		$display("checks=%0d mismatches=%0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic restart(input logic [1:0] code);
		rst_b <= 1'b0;
		shi <= code[1];
		slo <= code[0];
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
	endtask
	// Holds the request until waitrequest is seen low at an edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		rd <= ~w;
		wr <= w;
		addr <= a;
		wdata <= d;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (wreq !== 1'b0 && n < 20);
		rdata = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
		if (n >= 20)
		begin
			bad_count++;
			results();
		end
	endtask
	task automatic internal_defaults;
		fixed <= 2'h2;
		restart(2'h2);
		check(att, 1'b1);
		check({tten, eop, ppow, sen, een, src}, 9'h1b2);
		check(selfp, 1'b1);
		check({st.vendor_id, st.product_id}, {DEF_VID, DEF_PID});
		check(st.release_bcd, DEF_REL);
		check({st.compound, st.fixed_ports, st.cs_ganged}, 4'hd);
		check({maxp, hcur}, {DEF_MAXP_SELF, DEF_MAXP_SELF});
		bus(1'b0, REG_STATUS, 32'h0000_0000);
		check(rdata, 32'h0000_003b);
		bus(1'b0, 8'h80, 32'h0000_0000);
		check(rdata, 32'h0000_0000);
		bus(1'b1, DESC_VID_LSB, 32'h0000_00ff);
		check(st.vendor_id, DEF_VID);
		bus(1'b0, 8'h00, 32'h0000_0000);
		check(rdata, 32'h0000_0000);
	endtask
	task automatic power_change;
		oc <= 1'b1;
		repeat (4) @(posedge clk);
		check(ocr, 1'b0);
		repeat (10) @(posedge clk);
		check(ocr, 1'b1);
		oc <= 1'b0;
		sense <= 1'b0;
		repeat (2) @(posedge clk);
		check({att, pen, ppow}, 5'h00);
		repeat (300) @(posedge clk);
		check(att, 1'b0);
		repeat (110) @(posedge clk);
		check({att, selfp}, 2'h2);
		check({maxp, hcur}, {DEF_MAXP_BUS, DEF_MAXP_BUS});
	endtask
	task automatic serial_load;
		sense <= 1'b1;
		restart(2'h1);
		check(saddr, SERIAL_SLAVE_ADDR);
		check(att, 1'b0);
		check({src, sen, een}, 4'h6);
		bus(1'b1, 8'h00, 32'h0000_005a);
		bus(1'b1, 8'h04, 32'h0000_00a5);
		bus(1'b1, 8'h18, 32'h0000_00a0);
		bus(1'b1, 8'h24, 32'h0000_0004);
		bus(1'b1, 8'h2c, 32'h0000_0055);
		bus(1'b1, REG_CTRL, 32'h0000_0001);
		repeat (3) @(posedge clk);
		check({att, hs, pen}, 4'h9);
		check({st.vendor_id, maxp}, 24'ha55a_55);
		check({tten, eop, ppow, hcur}, 13'h0500);
	endtask
	task automatic strap_modes;
		restart(2'h3);
		check({src, sen, een, att}, 5'h1a);
		restart(2'h0);
		repeat (8) @(posedge clk);
		check({src, sen, een, att}, 5'h00);
	endtask
	initial
	begin
		{rst_b, shi, slo, oc, rd, wr, fixed, addr, wdata} = '0;
		sense = 1'b1;
		bad_count = 0;
		num_checks = 0;
		internal_defaults();
		power_change();
		serial_load();
		strap_modes();
		results();
	end
endmodule
`default_nettype wire
